// [hw/pkt_router.sv]
// Purpose: transport-layer router between the physical layer, logical modules and pass-through
// Assumes: phy stream and pass-through run on ref_clk_i; phy buffers do any clock crossing
// Notes: receive routes by format/transaction/destination; transmit is round robin
// Summary of operation
// - Router logic runs on its own system clock
// - Clock crossing happens in physical layer buffers
// - Logical module clocks share system clock source
// - Common clock advised for all datapath parts
// - Reset held one clock, released synchronously
// - During reset all outputs driven low
// - Leaving reset, no packets pending anywhere
// - Route packet by format and transaction code
// - Unknown or misaddressed packets: pass-through or drop
// - Physical error flag on the header word drops the packet
// - Transmit polls modules in round-robin order
// - Whole packet sent, then next module polled
// - Pass-through abort raises end-of-packet too
// - Destination mismatch versus configured base identifier
// - Pass-through port full duplex, 32 bits
module pkt_router
	import pkt_router_pkg::*;
(
	input wire logic ref_clk_i, // System clock, 10 MHz
	input wire logic resetn_i, // Synchronous reset, active low
	input wire logic [ID_W-1:0] base_id_i, // Configured base device identifier
	input wire logic pass_en_i, // Pass-through receive enabled; pass-through transmit is polled regardless
	// Physical layer receive
	input wire logic phy_rx_valid_i, // Receive word valid
	input wire logic [DATA_W-1:0] phy_rx_data_i, // Receive word
	input wire logic phy_rx_sop_i, // Receive start of packet
	input wire logic phy_rx_eop_i, // Receive end of packet
	input wire logic phy_rx_err_i, // Receive packet error flag
	output logic phy_rx_ready_o, // Router can take a word
	// Physical layer transmit
	output logic phy_tx_valid_o, // Transmit word valid
	output logic [DATA_W-1:0] phy_tx_data_o, // Transmit word
	output logic phy_tx_sop_o, // Transmit start of packet
	output logic phy_tx_eop_o, // Transmit end of packet
	output logic phy_tx_err_o, // Transmit abort
	input wire logic phy_tx_ready_i, // Physical layer takes word
	// Pass-through receive
	output logic pt_rx_valid_o, // Pass-through word valid
	output logic [DATA_W-1:0] pt_rx_data_o, // Pass-through word
	output logic pt_rx_sop_o, // Pass-through start of packet
	output logic pt_rx_eop_o, // Pass-through end of packet
	input wire logic pt_rx_ready_i, // User takes word
	// Pass-through transmit
	input wire logic pt_tx_valid_i, // User word valid
	input wire logic [DATA_W-1:0] pt_tx_data_i, // User word
	input wire logic pt_tx_sop_i, // User start of packet
	input wire logic pt_tx_eop_i, // User end of packet
	input wire logic pt_tx_err_i, // User abort, comes with eop
	output logic pt_tx_ready_o, // Router takes user word
	pkt_link_if.router link // Logical modules
);
	// one system clock
	// Everything here runs on ref_clk_i; the phy side buffers cross domains.
	// no crossing here
	// Phy stream arrives already in this domain, so no synchronisers are added.

	////////////////////////////////////////////////////////////////////////////////
	// Receive side: one-word output holding stage shared by all destinations
	rx_state_e rx_state;
	logic [MOD_W-1:0] rx_dest;
	logic out_busy;
	logic out_full;
	logic [DATA_W-1:0] out_data;
	logic out_sop;
	logic out_eop;
	logic [MOD_W-1:0] out_dest;
	logic out_taken;
	logic rx_accept;
	logic [MOD_W-1:0] next_dest;
	logic next_drop;
	logic [FMT_W-1:0] hdr_fmt;
	logic [TTYPE_W-1:0] hdr_tt;
	logic [ID_W-1:0] hdr_id;

	// Destination taking the staged word
	always_comb begin
		if (out_dest == MOD_PASS) begin
			out_taken = pt_rx_ready_i;
		end else begin
			out_taken = link.rx_ready[out_dest];
		end
	end

	assign out_busy = out_full && !out_taken;
	assign rx_accept = phy_rx_valid_i && phy_rx_ready_o;
	assign hdr_fmt = phy_rx_data_i[FMT_LSB +: FMT_W];
	assign hdr_tt = phy_rx_data_i[TTYPE_LSB +: TTYPE_W];
	assign hdr_id = phy_rx_data_i[DEST_LSB +: ID_W];

	// Header decode
	always_comb begin
		next_dest = MOD_PASS;
		next_drop = 1'b0;
		case (hdr_fmt)
			FMT_MAINT: next_dest = MOD_MAINT;
			FMT_WRITE: next_dest = MOD_WRITE;
			FMT_DBELL: next_dest = MOD_DBELL;
			default: next_dest = MOD_PASS;
		endcase
		if (!ttype_ok(hdr_fmt, hdr_tt) || (hdr_id != base_id_i)) begin
			next_dest = MOD_PASS;
		end
		if ((next_dest == MOD_PASS) && !pass_en_i) begin
			next_drop = 1'b1;
		end
		if (phy_rx_err_i) begin
			next_drop = 1'b1;
		end
	end

	// Words after a dropped header are always accepted; headers and forwarded words wait on the stage
	// ready held low in reset
	assign phy_rx_ready_o = resetn_i && ((rx_state == RX_DROP) || !out_busy);

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			rx_state <= RX_HDR;
			rx_dest <= MOD_MAINT;
		end else if (rx_accept) begin
			case (rx_state)
				RX_HDR: begin
					rx_dest <= next_dest;
					if (phy_rx_eop_i) begin
						rx_state <= RX_HDR;
					end else if (next_drop) begin
						rx_state <= RX_DROP;
					end else begin
						rx_state <= RX_FWD;
					end
				end
				RX_FWD: begin
					if (phy_rx_eop_i) begin
						rx_state <= RX_HDR;
					end
				end
				RX_DROP: begin
					if (phy_rx_eop_i) begin
						rx_state <= RX_HDR;
					end
				end
				default: rx_state <= RX_HDR;
			endcase
		end
	end

	// Staging register; an error mid-packet ends the packet early
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			out_full <= 1'b0;
			out_data <= '0;
			out_sop <= 1'b0;
			out_eop <= 1'b0;
			out_dest <= MOD_MAINT;
		end else if (rx_accept && (rx_state == RX_HDR) && !next_drop) begin
			out_full <= 1'b1;
			out_data <= phy_rx_data_i;
			out_sop <= 1'b1;
			out_eop <= phy_rx_eop_i;
			out_dest <= next_dest;
		end else if (rx_accept && (rx_state == RX_FWD)) begin
			out_full <= 1'b1;
			out_data <= phy_rx_data_i;
			out_sop <= 1'b0;
			out_eop <= phy_rx_eop_i || phy_rx_err_i;
			out_dest <= rx_dest;
		end else if (out_taken) begin
			out_full <= 1'b0;
		end
	end

	// Pass-through copy of the stage, loaded on the same edges so the handshake stays one deep
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			pt_rx_valid_o <= 1'b0;
			pt_rx_data_o <= '0;
			pt_rx_sop_o <= 1'b0;
			pt_rx_eop_o <= 1'b0;
		end else if (rx_accept && (rx_state == RX_HDR) && !next_drop) begin
			pt_rx_valid_o <= (next_dest == MOD_PASS);
			pt_rx_data_o <= phy_rx_data_i;
			pt_rx_sop_o <= 1'b1;
			pt_rx_eop_o <= phy_rx_eop_i;
		end else if (rx_accept && (rx_state == RX_FWD)) begin
			pt_rx_valid_o <= (rx_dest == MOD_PASS);
			pt_rx_data_o <= phy_rx_data_i;
			pt_rx_sop_o <= 1'b0;
			pt_rx_eop_o <= phy_rx_eop_i || phy_rx_err_i;
		end else if (out_taken) begin
			pt_rx_valid_o <= 1'b0;
		end
	end

	always_comb begin
		link.rx_valid = '0;
		if (out_full && (out_dest != MOD_PASS)) begin
			link.rx_valid[out_dest] = 1'b1;
		end
	end
	assign link.rx_data = out_data;
	assign link.rx_sop = out_sop;
	assign link.rx_eop = out_eop;

	////////////////////////////////////////////////////////////////////////////////
	// Transmit side: round-robin over logical modules then pass-through
	tx_state_e tx_state;
	logic [MOD_W-1:0] tx_ptr;
	logic src_valid;
	logic [DATA_W-1:0] src_data;
	logic src_sop;
	logic src_eop;
	logic src_err;
	logic src_take;

	// Source multiplexer
	always_comb begin
		if (tx_ptr == MOD_PASS) begin
			src_valid = pt_tx_valid_i;
			src_data = pt_tx_data_i;
			src_sop = pt_tx_sop_i;
			src_eop = pt_tx_eop_i || pt_tx_err_i;
			src_err = pt_tx_err_i;
		end else begin
			src_valid = link.tx_valid[tx_ptr];
			src_data = link.tx_data[tx_ptr*DATA_W +: DATA_W];
			src_sop = link.tx_sop[tx_ptr];
			src_eop = link.tx_eop[tx_ptr];
			src_err = 1'b0;
		end
	end

	assign src_take = src_valid && (!phy_tx_valid_o || phy_tx_ready_i);

	always_comb begin
		link.tx_ready = '0;
		pt_tx_ready_o = 1'b0;
		// Ready stays low in reset so no source sees a take
		if (tx_ptr == MOD_PASS) begin
			pt_tx_ready_o = resetn_i && (!phy_tx_valid_o || phy_tx_ready_i);
		end else begin
			link.tx_ready[tx_ptr] = resetn_i && (!phy_tx_valid_o || phy_tx_ready_i);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			tx_state <= TX_POLL;
			tx_ptr <= MOD_MAINT;
		end else begin
			case (tx_state)
				TX_POLL: begin
					if (src_take && !src_eop) begin
						tx_state <= TX_SEND;
					end else if (!src_valid || src_take) begin
						tx_ptr <= tx_ptr + 2'h1;
					end
				end
				TX_SEND: begin
					if (src_take && src_eop) begin
						tx_state <= TX_POLL;
						tx_ptr <= tx_ptr + 2'h1;
					end
				end
				default: tx_state <= TX_POLL;
			endcase
		end
	end

	// Output word register toward the physical layer
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			phy_tx_valid_o <= 1'b0;
			phy_tx_data_o <= '0;
			phy_tx_sop_o <= 1'b0;
			phy_tx_eop_o <= 1'b0;
			phy_tx_err_o <= 1'b0;
		end else if (src_take) begin
			phy_tx_valid_o <= 1'b1;
			phy_tx_data_o <= src_data;
			phy_tx_sop_o <= src_sop;
			phy_tx_eop_o <= src_eop;
			phy_tx_err_o <= src_err;
		end else if (phy_tx_ready_i) begin
			phy_tx_valid_o <= 1'b0;
		end
	end
endmodule

// [common/pkt_router_pkg.sv]
// Purpose: shared constants and types for the transport packet router and its logical side
// Assumes: one system clock, synchronous active-low reset
// Notes: header word layout is fixed; widths are fixed at the documented values
package pkt_router_pkg;
	localparam int DATA_W = 32;
	localparam int NUM_MOD = 3;
	localparam int MOD_W = 2;
	localparam int ID_W = 8;
	// Header word fields
	localparam int FMT_LSB = 28;
	localparam int FMT_W = 4;
	localparam int TTYPE_LSB = 24;
	localparam int TTYPE_W = 4;
	localparam int DEST_LSB = 16;
	// Format codes handled by logical modules (index = module number)
	localparam logic [FMT_W-1:0] FMT_MAINT = 4'h8;
	localparam logic [FMT_W-1:0] FMT_WRITE = 4'h5;
	localparam logic [FMT_W-1:0] FMT_DBELL = 4'ha;
	localparam logic [MOD_W-1:0] MOD_MAINT = 2'h0;
	localparam logic [MOD_W-1:0] MOD_WRITE = 2'h1;
	localparam logic [MOD_W-1:0] MOD_DBELL = 2'h2;
	localparam logic [MOD_W-1:0] MOD_PASS = 2'h3;
	localparam logic [MOD_W-1:0] MOD_DROP_CODE = 2'h3;
	localparam logic [ID_W-1:0] BASE_ID_DEFAULT = 8'h01;
	// Clock rule: sysclk may deviate from the reference by this many percent
	localparam int SYSCLK_DEV_PCT = 50;
	typedef enum logic [1:0] {RX_HDR, RX_FWD, RX_DROP} rx_state_e;
	typedef enum logic [0:0] {TX_POLL, TX_SEND} tx_state_e;

	// Valid transaction code for a format code
	function automatic logic ttype_ok(input logic [FMT_W-1:0] fmt, input logic [TTYPE_W-1:0] tt);
		logic ok;
		ok = 1'b0;
		case (fmt)
			FMT_MAINT: ok = (tt <= 4'h4);
			FMT_WRITE: ok = (tt == 4'h4) || (tt == 4'h5);
			FMT_DBELL: ok = (tt == 4'h0);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction
endpackage

// [common/pkt_link_if.sv]
// Purpose: stream link between the packet router and the logical layer side
// Assumes: single system clock, all signals synchronous to it
// Notes: rx is router-to-logic, tx is logic-to-router, one stream per module
interface pkt_link_if;
	import pkt_router_pkg::*;
	// Receive: router to logical modules (shared data, per-module valid)
	logic [NUM_MOD-1:0] rx_valid;
	logic [DATA_W-1:0] rx_data;
	logic rx_sop;
	logic rx_eop;
	logic [NUM_MOD-1:0] rx_ready;
	// Transmit: logical modules to router
	logic [NUM_MOD-1:0] tx_valid;
	logic [NUM_MOD*DATA_W-1:0] tx_data;
	logic [NUM_MOD-1:0] tx_sop;
	logic [NUM_MOD-1:0] tx_eop;
	logic [NUM_MOD-1:0] tx_ready;
	modport router (output rx_valid, rx_data, rx_sop, rx_eop, input rx_ready,
		input tx_valid, tx_data, tx_sop, tx_eop, output tx_ready);
	modport logic_side (input rx_valid, rx_data, rx_sop, rx_eop, output rx_ready,
		output tx_valid, tx_data, tx_sop, tx_eop, input tx_ready);
endinterface

// [hw/pkt_logic_end.sv]
// Purpose: logical-layer end of the router link, one stream per module
// Assumes: same system clock and reset as the router
// Notes: each module exposes a plain user stream; no buffering beyond the wires
module pkt_logic_end
	import pkt_router_pkg::*;
(
	input wire logic ref_clk_i, // System clock
	input wire logic resetn_i, // Synchronous reset, active low
	pkt_link_if.logic_side link, // Router side
	output logic [NUM_MOD-1:0] usr_rx_valid_o, // Received word valid per module
	output logic [DATA_W-1:0] usr_rx_data_o, // Received word
	output logic usr_rx_sop_o, // Received start of packet
	output logic usr_rx_eop_o, // Received end of packet
	input wire logic [NUM_MOD-1:0] usr_rx_ready_i, // Module takes word
	input wire logic [NUM_MOD-1:0] usr_tx_valid_i, // Module word valid
	input wire logic [NUM_MOD*DATA_W-1:0] usr_tx_data_i, // Module words
	input wire logic [NUM_MOD-1:0] usr_tx_sop_i, // Module start of packet
	input wire logic [NUM_MOD-1:0] usr_tx_eop_i, // Module end of packet
	output logic [NUM_MOD-1:0] usr_tx_ready_o // Router takes word
);
	// common datapath clock
	// Both ends use ref_clk_i directly, so no fabric crossing exists.
	logic rst_q;

	always_ff @(posedge ref_clk_i) begin
		rst_q <= !resetn_i;
	end

	// Pass-through of streams; valids gated by reset registered one clock late
	always_comb begin
		usr_rx_valid_o = rst_q ? '0 : link.rx_valid;
		usr_rx_data_o = link.rx_data;
		usr_rx_sop_o = link.rx_sop;
		usr_rx_eop_o = link.rx_eop;
		usr_tx_ready_o = link.tx_ready;
		link.rx_ready = usr_rx_ready_i;
		link.tx_valid = rst_q ? '0 : usr_tx_valid_i;
		link.tx_data = usr_tx_data_i;
		link.tx_sop = usr_tx_sop_i;
		link.tx_eop = usr_tx_eop_i;
	end
endmodule

// [bench/pkt_router_assertions.sv]
// Purpose: link checker between the router and the logical end
// Assumes: one clock, synchronous active-low reset
// Notes: sees only the link signals, so base id and errors are judged by the bench
module pkt_router_assertions
	import pkt_router_pkg::*;
(
	input wire logic ref_clk_i, // System clock
	input wire logic resetn_i, // Reset, active low
	input wire logic [NUM_MOD-1:0] rx_valid, // Router word valid
	input wire logic [DATA_W-1:0] rx_data, // Router word
	input wire logic rx_sop, // Start of packet
	input wire logic rx_eop, // End of packet
	input wire logic [NUM_MOD-1:0] rx_ready, // Module takes word
	input wire logic [NUM_MOD-1:0] tx_valid, // Module word valid
	input wire logic [NUM_MOD*DATA_W-1:0] tx_data, // Module words
	input wire logic [NUM_MOD-1:0] tx_sop, // Module start
	input wire logic [NUM_MOD-1:0] tx_eop, // Module end
	input wire logic [NUM_MOD-1:0] tx_ready // Router takes word
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	////////////////////////////////////////////////////////////////////////////////
	// Open transmit packet; a switch of source inside it would interleave
	logic [NUM_MOD-1:0] take;
	logic [NUM_MOD-1:0] own;
	logic busy;
	logic [FMT_W-1:0] want_fmt;
	assign take = tx_valid & tx_ready;
	assign want_fmt = rx_valid[0] ? FMT_MAINT : (rx_valid[1] ? FMT_WRITE : FMT_DBELL);
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			busy <= 1'b0;
			own <= '0;
		end else if (take != '0) begin
			busy <= (take & tx_eop) == '0;
			own <= take;
		end
	end
	sequence eop_taken;
		(take & tx_eop) != '0;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	rst_quiet_a: assert property (disable iff (1'b0) !resetn_i |=> rx_valid == '0)
		else $error("module stream active during reset");
	rst_exit_a: assert property ($rose(resetn_i) |-> rx_valid == '0)
		else $error("stale word after reset");
	rx_onehot_a: assert property ($onehot0(rx_valid))
		else $error("word offered to two modules");
	rx_hold_a: assert property (rx_valid != '0 && (rx_valid & rx_ready) == '0 |=>
		$stable(rx_valid) && $stable(rx_data) && $stable(rx_eop))
		else $error("receive word changed before taken");
	rx_route_a: assert property (rx_valid != '0 && rx_sop |-> rx_data[FMT_LSB+:FMT_W] == want_fmt)
		else $error("header sent to wrong module");
	tx_onehot_a: assert property ($onehot0(tx_ready))
		else $error("two modules polled at once");
	tx_whole_a: assert property (busy |-> (tx_ready & ~own) == '0)
		else $error("packets interleaved");
	tx_next_a: assert property (eop_taken |=> (tx_ready & $past(take)) == '0)
		else $error("polling stayed on finished module");
endmodule

// [bench/pkt_router_tb_top.sv]
// Purpose: router and logical end joined, checked against a queue model
// Assumes: pass-through enabled for the later receive tests; slot 3 of the queues is pass-through
// Notes: stalls on both sides come from the seeded random stream
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module pkt_router_tb_top
	import pkt_router_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i = 0, resetn_i = 0, pass_en_i = 0, phy_rx_valid_i = 0, phy_rx_sop_i = 0;
	logic phy_rx_eop_i = 0, phy_rx_err_i = 0, phy_tx_ready_i = 0, pt_rx_ready_i = 0;
	logic pt_tx_valid_i = 0, pt_tx_sop_i = 0, pt_tx_eop_i = 0, pt_tx_err_i = 0;
	logic [ID_W-1:0] base_id_i = '0;
	logic [DATA_W-1:0] phy_rx_data_i = '0, pt_tx_data_i = '0, phy_tx_data_o, pt_rx_data_o;
	logic [DATA_W-1:0] usr_rx_data_o;
	logic phy_rx_ready_o, phy_tx_valid_o, phy_tx_sop_o, phy_tx_eop_o, phy_tx_err_o;
	logic pt_rx_valid_o, pt_rx_sop_o, pt_rx_eop_o, pt_tx_ready_o, usr_rx_sop_o, usr_rx_eop_o;
	logic [NUM_MOD-1:0] usr_rx_ready_i = '0, usr_tx_valid_i = '0, usr_tx_sop_i = '0;
	logic [NUM_MOD-1:0] usr_tx_eop_i = '0, usr_rx_valid_o, usr_tx_ready_o;
	logic [NUM_MOD*DATA_W-1:0] usr_tx_data_i = '0;
	int bad_count = 0, samples_checked = 0, seed = 14, cycles = 0, last_src = -1;
	logic [33:0] rxq[NUM_MOD+1][$], txq[NUM_MOD+1][$], w;
	int nxt, pk_left[NUM_MOD+1];
	logic [1:0] src;
	logic [3:0] fmts[4] = '{FMT_MAINT, FMT_WRITE, FMT_DBELL, 4'h3};
	pkt_link_if link ();
	pkt_router u_pkt_router (.ref_clk_i, .resetn_i, .base_id_i, .pass_en_i, .phy_rx_valid_i,
		.phy_rx_data_i, .phy_rx_sop_i, .phy_rx_eop_i, .phy_rx_err_i, .phy_rx_ready_o,
		.phy_tx_valid_o, .phy_tx_data_o, .phy_tx_sop_o, .phy_tx_eop_o, .phy_tx_err_o,
		.phy_tx_ready_i, .pt_rx_valid_o, .pt_rx_data_o, .pt_rx_sop_o, .pt_rx_eop_o, .pt_rx_ready_i,
		.pt_tx_valid_i, .pt_tx_data_i, .pt_tx_sop_i, .pt_tx_eop_i, .pt_tx_err_i, .pt_tx_ready_o,
		.link(link));
	pkt_logic_end u_pkt_logic_end (.ref_clk_i, .resetn_i, .link(link), .usr_rx_valid_o,
		.usr_rx_data_o, .usr_rx_sop_o, .usr_rx_eop_o, .usr_rx_ready_i, .usr_tx_valid_i,
		.usr_tx_data_i, .usr_tx_sop_i, .usr_tx_eop_i, .usr_tx_ready_o);
	pkt_router_assertions u_pkt_router_assertions (.ref_clk_i, .resetn_i,
		.rx_valid(link.rx_valid), .rx_data(link.rx_data), .rx_sop(link.rx_sop),
		.rx_eop(link.rx_eop), .rx_ready(link.rx_ready), .tx_valid(link.tx_valid),
		.tx_data(link.tx_data), .tx_sop(link.tx_sop), .tx_eop(link.tx_eop),
		.tx_ready(link.tx_ready));
	////////////////////////////////////////////////////////////////////////////////
	// Clock, random stalls and the hang limit
	always #50 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		usr_rx_ready_i <= NUM_MOD'($random(seed));
		phy_tx_ready_i <= 1'($random(seed));
		pt_rx_ready_i <= 1'($random(seed));
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			end_of_test();
		end
	end
	// Model check of every word taken on either side
	always @(posedge ref_clk_i) if (resetn_i) begin
		for (int i = 0; i < NUM_MOD; i++)
			if (usr_rx_valid_o[i] === 1'b1 && usr_rx_ready_i[i]) begin
				if (rxq[i].size() == 0) `CHK("rx_extra", 1'b0, 1'b1)
				else begin
					w = rxq[i].pop_front();
					`CHK("rx_word", w, {usr_rx_sop_o, usr_rx_eop_o, usr_rx_data_o})
				end
			end
		if (pt_rx_valid_o === 1'b1 && pt_rx_ready_i) begin
			if (rxq[MOD_PASS].size() == 0) `CHK("pt_extra", 1'b0, 1'b1)
			else begin
				w = rxq[MOD_PASS].pop_front();
				`CHK("pt_word", w, {pt_rx_sop_o, pt_rx_eop_o, pt_rx_data_o})
			end
		end
		if (phy_tx_valid_o === 1'b1 && phy_tx_ready_i) begin
			src = phy_tx_data_o[29:28];
			// Next source with packets left, in cyclic order
			if (phy_tx_sop_o === 1'b1 && last_src >= 0) begin
				nxt = (last_src + 1) % (NUM_MOD + 1);
				while (pk_left[nxt] == 0 && nxt != last_src) nxt = (nxt + 1) % (NUM_MOD + 1);
				`CHK("rr_next", 2'(nxt), src)
			end
			if (phy_tx_sop_o === 1'b1) last_src = src;
			if (phy_tx_eop_o === 1'b1) pk_left[src]--;
			w = (txq[src].size() > 0) ? txq[src].pop_front() : '1;
			`CHK("tx_word", w, {phy_tx_sop_o, phy_tx_eop_o, phy_tx_data_o})
			`CHK("tx_err", phy_tx_eop_o && (src == MOD_PASS), phy_tx_err_o)
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Where a header should go; NUM_MOD is pass-through, NUM_MOD+1 dropped
	function automatic int route(logic [3:0] f, logic [3:0] t, logic ok, logic e);
		int m;
		m = NUM_MOD;
		case (f)
			FMT_MAINT: if (t <= 4'h4) m = 0;
			FMT_WRITE: if (t == 4'h4 || t == 4'h5) m = 1;
			FMT_DBELL: if (t == 4'h0) m = 2;
			default: m = NUM_MOD;
		endcase
		if (!ok) m = NUM_MOD;
		if (m == NUM_MOD && !pass_en_i) m = NUM_MOD + 1;
		if (e) m = NUM_MOD + 1;
		return m;
	endfunction
	task automatic rx_word(input logic [33:0] d, input logic e);
		phy_rx_valid_i <= 1'b1;
		{phy_rx_sop_i, phy_rx_eop_i, phy_rx_data_i} <= d;
		phy_rx_err_i <= e;
		do @(posedge ref_clk_i); while (phy_rx_ready_o !== 1'b1);
	endtask
	// Back-to-back packets, good, misaddressed, unknown and errored mixed
	task automatic rx_test(input int n);
		logic [3:0] f, t;
		logic e, ok;
		int len, m;
		for (int j = 0; j < n; j++) begin
			f = fmts[$random(seed) & 3];
			t = 4'($random(seed));
			e = ($random(seed) & 7) == 0;
			ok = ($random(seed) & 3) != 0;
			len = 1 + ($random(seed) & 3);
			m = route(f, t, ok, e);
			for (int k = 0; k < len; k++) begin
				w = {k == 0, k == len - 1, 32'($random(seed))};
				if (k == 0) w[31:0] = {f, t, ok ? base_id_i : ~base_id_i, w[15:0]};
				if (m <= NUM_MOD) rxq[m].push_back(w);
				rx_word(w, e);
			end
		end
		phy_rx_valid_i <= 1'b0;
		repeat (100) @(posedge ref_clk_i);
		for (int i = 0; i <= NUM_MOD; i++) `CHK("rx_left", 32'h0, 32'(rxq[i].size()))
		$display("test rx done");
	endtask
	task automatic tx_pkts(input int m);
		int len;
		for (int p = 0; p < 4; p++) begin
			len = 1 + ($random(seed) & 3);
			for (int k = 0; k < len; k++) begin
				txq[m].push_back({k == 0, k == len - 1, 2'h0, 2'(m), 12'($random(seed)), 16'(k)});
				usr_tx_valid_i[m] <= 1'b1;
				{usr_tx_sop_i[m], usr_tx_eop_i[m], usr_tx_data_i[m*DATA_W+:DATA_W]} <= txq[m][$];
				do @(posedge ref_clk_i); while (usr_tx_ready_o[m] !== 1'b1);
			end
		end
		usr_tx_valid_i[m] <= 1'b0;
	endtask
	// Pass-through packets, each ended by an abort
	task automatic pt_pkts();
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 2; k++) begin
				txq[MOD_PASS].push_back({k == 0, k == 1, 2'h0, MOD_PASS, 12'($random(seed)), 16'(k)});
				pt_tx_valid_i <= 1'b1;
				{pt_tx_sop_i, pt_tx_eop_i, pt_tx_data_i} <= txq[MOD_PASS][$];
				pt_tx_err_i <= (k == 1);
				do @(posedge ref_clk_i); while (pt_tx_ready_o !== 1'b1);
			end
		end
		pt_tx_valid_i <= 1'b0;
		pt_tx_err_i <= 1'b0;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		base_id_i = 8'($random(seed));
		repeat (8) @(posedge ref_clk_i);
		`CHK("tx_rst", 1'b0, phy_tx_valid_o)
		`CHK("rx_rst", 3'h0, usr_rx_valid_o)
		`CHK("rdy_rst", 1'b0, phy_rx_ready_o)
		resetn_i <= 1'b1;
		@(posedge ref_clk_i);
		rx_test(40);
		pk_left = '{4, 4, 4, 2};
		fork
			tx_pkts(0);
			tx_pkts(1);
			tx_pkts(2);
			pt_pkts();
		join
		repeat (100) @(posedge ref_clk_i);
		for (int i = 0; i <= NUM_MOD; i++) `CHK("tx_left", 32'h0, 32'(txq[i].size()))
		$display("test tx done");
		// Misaddressed and unknown packets now go to the pass-through port
		pass_en_i <= 1'b1;
		@(posedge ref_clk_i);
		rx_test(30);
		// Reset in mid-packet; the half packet must not surface later
		rx_word({2'b10, FMT_MAINT, 4'h0, base_id_i, 16'h0}, 1'b0);
		phy_rx_valid_i <= 1'b0;
		resetn_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		@(posedge ref_clk_i);
		rx_test(10);
		end_of_test();
	end
endmodule
